// ### slice_cmd_params.svh
`ifndef SLICE_CMD_PARAMS_SVH
`define SLICE_CMD_PARAMS_SVH
// ----------------------------------------
// command header encodings
// ----------------------------------------
`define CMD_TYPE_VIDEO 3'h3
`define CMD_PIPE_DEC 2'h2
`define CMD_OPC_AVC 3'h4
`define SUB_BASE 8'h04
`define SUB_PIC 8'h00
`define SUB_QM 8'h01
`define SUB_SLICE 8'h02
`define SUB_BUF 8'h03
`define SUB_OBJ 8'h08
`define BASE_LEN 16'h0001
// ----------------------------------------
// address layout
// ----------------------------------------
`define ADDR_LSB 12
`define PAGE_W 20
`define RSVD_ZERO 12'h000
`define PAGE_ZERO 20'h00000
// ----------------------------------------
// body word positions and buffer
// ----------------------------------------
`define DW_ONE 17'h00001
`define DW_TWO 17'h00002
`define BUF_FULL 2'h2
`endif

// ### slice_cmd_pkg.sv
package slice_cmd_pkg;
    typedef struct packed {
        logic [2:0] cmd_type;
        logic [1:0] pipe;
        logic [2:0] opcode;
        logic [7:0] sub_opcode;
        logic [15:0] length;
    } cmd_hdr_s;

    typedef enum logic [2:0] {
        KIND_BASE, KIND_PIC, KIND_QM, KIND_SLICE, KIND_BUF, KIND_OBJ, KIND_NONE
    } cmd_kind_e;

    typedef struct packed {
        cmd_kind_e kind;
        logic [31:0] data;
    } state_word_s;
endpackage : slice_cmd_pkg

// ### slice_cmd_sequencer.sv
// Contract
// - usable after reset without init command
// - repeated state command: last arrival applies
// - flush per slice; parser stalls until done
// - base header type, pipe, opcode, sub-opcode fixed
// - base length field 0001h, three dwords
// - base in dword1 31:12, low zero
// - start address offset by stored base
// - fetch at or above bound returns zero
// - zero bound disables range check
// - bound ignored without indirect data
// - state persists until reprogram or reset
// - state commands whole dwords, sizes vary
// - hardware reset clears pipeline at once
`include "slice_cmd_params.svh"
module slice_cmd_sequencer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hw_reset,
    // command dword stream
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_data,
    output logic cmd_ready,
    // state words to the decoder
    output logic st_valid,
    output slice_cmd_pkg::state_word_s st_word,
    // slice launch and completion
    output logic slice_start,
    output logic [31:0] fetch_addr,
    output logic [31:0] fetch_len,
    output logic fetch_indirect,
    output logic busy,
    input wire logic slice_done,
    // indirect data return
    input wire logic rd_valid,
    input wire logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    output logic out_valid,
    output logic [31:0] out_data,
    // configuration and status
    output logic [19:0] indirect_base,
    output logic [19:0] upper_bound,
    output logic seq_error,
    output logic hdr_error
);
    import slice_cmd_pkg::*;
    typedef enum logic [1:0] {ST_HDR, ST_BODY, ST_WAIT} parse_e;
    parse_e state;
    cmd_kind_e cur_kind;
    cmd_kind_e last_state;
    logic clr;
    logic [31:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic [1:0] next_count;
    logic push;
    logic pop;
    logic [31:0] word;
    cmd_hdr_s hdr;
    cmd_kind_e hdr_kind;
    logic [16:0] remain;
    logic [16:0] dw_idx;
    logic [19:0] new_base;
    logic [31:0] obj_len;
    logic [31:0] obj_start;
    logic base_seen;
    logic pic_seen;
    function automatic cmd_kind_e decode(input cmd_hdr_s h);
        decode = KIND_NONE;
        if (h.cmd_type == `CMD_TYPE_VIDEO && h.pipe == `CMD_PIPE_DEC && h.opcode == `CMD_OPC_AVC) begin
            unique case (h.sub_opcode)
                `SUB_BASE: decode = KIND_BASE;
                `SUB_PIC: decode = KIND_PIC;
                `SUB_QM: decode = KIND_QM;
                `SUB_SLICE: decode = KIND_SLICE;
                `SUB_BUF: decode = KIND_BUF;
                `SUB_OBJ: decode = KIND_OBJ;
                default: decode = KIND_NONE;
            endcase
        end
    endfunction : decode

    assign clr = !rst_n || hw_reset;
    assign word = mem[rd_ptr];
    assign hdr = word;
    assign hdr_kind = decode(hdr);
    assign push = cmd_valid && cmd_ready;
    assign pop = (count != 2'h0) && (state != ST_WAIT);
    assign next_count = count + {1'b0, push} - {1'b0, pop};

    // ----------------------------------------
    // two-entry command buffer
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            count <= 2'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            count <= next_count;
            cmd_ready <= next_count < `BUF_FULL;
            if (push) begin
                wr_ptr <= !wr_ptr;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= cmd_data;
        end
    end

    // ----------------------------------------
    // command parser
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            state <= ST_HDR;
            cur_kind <= KIND_NONE;
            remain <= 17'h0;
            dw_idx <= 17'h0;
        end else begin
            unique case (state)
                ST_HDR: begin
                    if (pop) begin
                        cur_kind <= hdr_kind;
                        remain <= {1'b0, hdr.length} + `DW_ONE;
                        dw_idx <= `DW_ONE;
                        state <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (pop) begin
                        dw_idx <= dw_idx + `DW_ONE;
                        remain <= remain - `DW_ONE;
                        if (remain == `DW_ONE) begin
                            state <= (cur_kind == KIND_OBJ) ? ST_WAIT : ST_HDR;
                        end
                    end
                end
                ST_WAIT: begin
                    if (slice_done) begin
                        state <= ST_HDR;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // indirect base and bound
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            indirect_base <= `PAGE_ZERO;
            upper_bound <= `PAGE_ZERO;
            new_base <= `PAGE_ZERO;
        end else if (state == ST_BODY && pop && cur_kind == KIND_BASE) begin
            if (dw_idx == `DW_ONE) begin
                new_base <= word[31:`ADDR_LSB];
            end
            if (dw_idx == `DW_TWO) begin
                indirect_base <= new_base;
                upper_bound <= word[31:`ADDR_LSB];
            end
        end
    end

    // ----------------------------------------
    // state word forwarding
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            st_valid <= 1'b0;
            st_word <= '0;
        end else begin
            st_valid <= state == ST_BODY && pop && cur_kind inside {KIND_PIC, KIND_QM, KIND_SLICE, KIND_BUF};
            st_word <= '{kind: cur_kind, data: word};
        end
    end

    // ----------------------------------------
    // slice launch
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            obj_len <= 32'h0;
            obj_start <= 32'h0;
            slice_start <= 1'b0;
            fetch_addr <= 32'h0;
            fetch_len <= 32'h0;
            fetch_indirect <= 1'b0;
            busy <= 1'b0;
        end else begin
            slice_start <= 1'b0;
            if (state == ST_BODY && pop && cur_kind == KIND_OBJ) begin
                if (dw_idx == `DW_ONE) begin
                    obj_len <= word;
                end
                if (dw_idx == `DW_TWO) begin
                    obj_start <= word;
                end
                if (remain == `DW_ONE) begin
                    slice_start <= 1'b1;
                    busy <= 1'b1;
                    fetch_len <= (dw_idx == `DW_ONE) ? word : obj_len;
                    fetch_indirect <= (dw_idx == `DW_ONE) ? (word != 32'h0) : (obj_len != 32'h0);
                    fetch_addr <= {indirect_base, `RSVD_ZERO} + ((dw_idx == `DW_TWO) ? word : obj_start);
                end
            end else if (state == ST_WAIT && slice_done) begin
                busy <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // indirect data range check
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            out_valid <= 1'b0;
            out_data <= 32'h0;
        end else begin
            out_valid <= rd_valid;
            if (fetch_indirect && upper_bound != `PAGE_ZERO && rd_addr[31:`ADDR_LSB] >= upper_bound) begin
                out_data <= 32'h0;
            end else begin
                out_data <= rd_data;
            end
        end
    end

    // ----------------------------------------
    // order and header checks
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            base_seen <= 1'b0;
            pic_seen <= 1'b0;
            last_state <= KIND_NONE;
            seq_error <= 1'b0;
            hdr_error <= 1'b0;
        end else if (state == ST_HDR && pop) begin
            unique case (hdr_kind)
                KIND_BASE: begin
                    base_seen <= 1'b1;
                    if (hdr.length != `BASE_LEN) begin
                        hdr_error <= 1'b1;
                    end
                    if (last_state != KIND_NONE) begin
                        seq_error <= 1'b1;
                    end
                end
                KIND_PIC, KIND_QM, KIND_SLICE, KIND_BUF: begin
                    last_state <= hdr_kind;
                    if (hdr_kind == KIND_PIC) begin
                        pic_seen <= 1'b1;
                    end
                    if (!base_seen) begin
                        seq_error <= 1'b1;
                    end
                    if (last_state != KIND_NONE && hdr_kind < last_state) begin
                        seq_error <= 1'b1;
                    end
                end
                KIND_OBJ: begin
                    last_state <= KIND_NONE;
                    if (!pic_seen) begin
                        seq_error <= 1'b1;
                    end
                end
                KIND_NONE: begin
                    hdr_error <= 1'b1;
                end
            endcase
        end else if (state == ST_BODY && pop && cur_kind == KIND_BASE && dw_idx == `DW_ONE) begin
            if (word[`ADDR_LSB-1:0] != `RSVD_ZERO) begin
                hdr_error <= 1'b1;
            end
        end
    end
endmodule : slice_cmd_sequencer

// ### slice_cmd_sequencer_chk.sv
// ----------------------------------------
// sequencer port checker
// ----------------------------------------
module slice_cmd_sequencer_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hw_reset,
    // observed ports
    input wire logic cmd_ready,
    input wire logic slice_start,
    input wire logic [31:0] fetch_len,
    input wire logic fetch_indirect,
    input wire logic busy,
    input wire logic slice_done,
    input wire logic rd_valid,
    input wire logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic out_valid,
    input wire logic [31:0] out_data,
    input wire logic [19:0] indirect_base,
    input wire logic [19:0] upper_bound
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    AST_HW_CLEAR: assert property (hw_reset |=> !cmd_ready && !busy && indirect_base == 20'h00000)
        else $error("pipeline not cleared");
    AST_BUSY_HOLD: assert property (busy && !slice_done && !hw_reset |=> busy)
        else $error("busy dropped early");
    AST_BUSY_END: assert property (busy && slice_done && !hw_reset |=> !busy)
        else $error("busy held after done");
    AST_OOB_ZERO: assert property (rd_valid && !hw_reset && fetch_indirect && upper_bound != 20'h00000
        && rd_addr[31:12] >= upper_bound |=> out_valid && out_data == 32'h0)
        else $error("out of bound data not zero");
    AST_NO_BOUND: assert property (rd_valid && !hw_reset && upper_bound == 20'h00000 |=> out_valid
        && out_data == $past(rd_data))
        else $error("unbounded data altered");
    AST_NO_IND: assert property (rd_valid && !hw_reset && !fetch_indirect |=> out_data == $past(rd_data))
        else $error("direct data altered");
    AST_IND_FLAG: assert property (slice_start |-> fetch_indirect == (fetch_len != 32'h0))
        else $error("indirect flag wrong");
    AST_BASE_HOLD: assert property (busy && !hw_reset |=> $stable(indirect_base) && $stable(upper_bound))
        else $error("base changed during slice");
endmodule : slice_cmd_sequencer_chk

bind slice_cmd_sequencer slice_cmd_sequencer_chk slice_cmd_sequencer_chk_inst (.*);

// ### slice_decoder_model.sv
// ----------------------------------------
// decoder and memory stand-in
// ----------------------------------------
module slice_decoder_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hw_reset,
    // slice launch and completion
    input wire logic slice_start,
    input wire logic [31:0] fetch_addr,
    input wire logic [7:0] dly,
    output logic slice_done,
    // memory return
    output logic rd_valid,
    output logic [31:0] rd_addr,
    output logic [31:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run;
    logic [7:0] cnt;
    always_ff @(posedge clk_sys) begin
        if (!rst_n || hw_reset) begin
            run <= 1'b0;
            cnt <= 8'h00;
            slice_done <= 1'b0;
            rd_valid <= 1'b0;
            rd_addr <= 32'h0;
            rd_data <= 32'h0;
        end else begin
            slice_done <= run && cnt == 8'h00;
            run <= slice_start || (run && cnt != 8'h00);
            cnt <= slice_start ? dly : cnt - 8'h01;
            rd_valid <= slice_start;
            rd_addr <= slice_start ? fetch_addr : ~rd_addr;
            rd_data <= slice_start ? ~fetch_addr : ~rd_data;
        end
    end
endmodule : slice_decoder_model

// ### tb_slice_cmd_sequencer.sv
module tb_slice_cmd_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import slice_cmd_pkg::*;
    logic clk_sys, rst_n, hw_reset, cmd_valid, cmd_ready, st_valid, slice_start, fetch_indirect;
    logic busy, slice_done, rd_valid, out_valid, seq_error, hdr_error;
    logic [31:0] cmd_data, fetch_addr, fetch_len, rd_addr, rd_data, out_data;
    logic [31:0] seen = 32'h0;
    logic [19:0] indirect_base, upper_bound;
    logic [7:0] dly;
    state_word_s st_word, st_seen;
    int errors = 0;
    int num_checks = 0;
    slice_cmd_sequencer slice_cmd_sequencer_inst (.*);
    slice_decoder_model slice_decoder_model_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (out_valid === 1'b1) seen <= out_data;
    always @(posedge clk_sys) if (st_valid === 1'b1) st_seen <= st_word;
    task close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task send(input logic [31:0] w);
        logic r;
        if (cmd_valid !== 1'b1) @(posedge clk_sys);
        #2 cmd_valid = 1'b1;
        cmd_data = w;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_sys) r = cmd_ready;
            @(posedge clk_sys);
            if (r === 1'b1) return;
        end
        chk("cmd_ready", 32'h1, 32'h0);
        close_out;
    endtask : send
    task idle;
        #2 cmd_valid = 1'b0;
    endtask : idle
    task cmd(input logic [7:0] sub, input logic [31:0] d1, input logic [31:0] d2);
        send({3'h3, 2'h2, 3'h4, sub, 16'h0001});
        send(d1);
        send(d2);
        idle;
    endtask : cmd
    task wait_busy(input logic lvl);
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_sys);
            if (busy === lvl) return;
        end
        chk("busy", lvl, busy);
        close_out;
    endtask : wait_busy
    task obj(input bit st, input logic [31:0] len, input logic [31:0] start, input logic [7:0] d);
        dly = d;
        if (st) for (int k = 0; k < 4; k++) cmd(k[7:0], 32'h0, 32'h0);
        cmd(8'h08, len, start);
        wait_busy(1'b1);
    endtask : obj
    task fin(input logic [31:0] exp);
        wait_busy(1'b0);
        chk("out", exp, seen);
    endtask : fin
    task hwr;
        @(posedge clk_sys);
        #2 hw_reset = 1'b1;
        @(posedge clk_sys);
        #2 hw_reset = 1'b0;
        chk("base", 32'h0, {12'h000, indirect_base});
        chk("hdr", 32'h0, hdr_error);
        chk("seq", 32'h0, seq_error);
    endtask : hwr
    initial begin
        rst_n = 1'b0;
        hw_reset = 1'b0;
        cmd_valid = 1'b0;
        cmd_data = 32'h0;
        dly = 8'h01;
        repeat (12) @(posedge clk_sys);
        #2 rst_n = 1'b1;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk("rdy", 32'h1, cmd_ready);
        chk("bnd", 32'h0, upper_bound);
        cmd(8'h04, 32'h00001000, 32'h00009000);
        send({3'h3, 2'h2, 3'h4, 8'h04, 16'h0001});
        send(32'h00005000);
        idle;
        repeat (3) @(negedge clk_sys);
        chk("base", 32'h1, indirect_base);
        send(32'h00008000);
        idle;
        repeat (4) @(negedge clk_sys);
        chk("base", 32'h5, indirect_base);
        chk("bnd", 32'h8, upper_bound);
        $display("test base setup done");
        obj(1'b1, 32'h4, 32'h100, 8'h14);
        chk("addr", 32'h5100, fetch_addr);
        chk("len", 32'h4, fetch_len);
        send({3'h3, 2'h2, 3'h4, 8'h00, 16'h0001});
        send(32'h0);
        idle;
        repeat (2) @(negedge clk_sys);
        chk("rdy", 32'h0, cmd_ready);
        fin(~32'h5100);
        send(32'h00000abc);
        idle;
        repeat (4) @(negedge clk_sys);
        chk("st_kind", KIND_PIC, st_seen.kind);
        chk("st_data", 32'h00000abc, st_seen.data);
        obj(1'b1, 32'h0, 32'h9000, 8'h01);
        chk("ind", 32'h0, fetch_indirect);
        fin(~32'he000);
        obj(1'b0, 32'h4, 32'h0, 8'h01);
        chk("addr", 32'h5000, fetch_addr);
        fin(~32'h5000);
        chk("seq", 32'h0, seq_error);
        $display("test slices done");
        hwr();
        cmd(8'h04, 32'h00005000, 32'h00006000);
        obj(1'b1, 32'h4, 32'h1000, 8'h01);
        fin(32'h0);
        hwr();
        cmd(8'h04, 32'h00003000, 32'h0);
        obj(1'b1, 32'h4, 32'h20000, 8'h01);
        fin(~32'h23000);
        $display("test bounds done");
        hwr();
        cmd(8'h00, 32'h0, 32'h0);
        repeat (4) @(negedge clk_sys);
        chk("seq", 32'h1, seq_error);
        hwr();
        cmd(8'h04, 32'h00005001, 32'h0);
        repeat (4) @(negedge clk_sys);
        chk("hdr", 32'h1, hdr_error);
        hwr();
        send({3'h3, 2'h1, 3'h4, 8'h04, 16'h0001});
        send(32'h0);
        send(32'h0);
        idle;
        repeat (4) @(negedge clk_sys);
        chk("hdr", 32'h1, hdr_error);
        hwr();
        send({3'h3, 2'h2, 3'h4, 8'h04, 16'h0002});
        repeat (3) send(32'h00001000);
        idle;
        repeat (4) @(negedge clk_sys);
        chk("hdr", 32'h1, hdr_error);
        $display("test errors done");
        close_out;
    end
endmodule : tb_slice_cmd_sequencer
